/* core/cap_sense_ctrl.sv */
`timescale 1ns/1ns
module cap_sense_ctrl #(
	parameter bit HAS_PORT1_PIN4 = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        conv_done_i,
	input  wire logic        end_of_scan_i,
	input  wire logic        comp_over_i,
	input  wire logic        suspended_i,
	output logic      [13:0] channel_connect_o,
	output logic      [2:0]  gain_select_o,
	output logic             converter_enable_o,
	output logic             wake_o,
	output logic             irq_o
);
	sense_cfg_if cfg ();

	logic [3:0]  channel_select_ff;
	logic [7:0]  mode_ff;
	logic [7:0]  mode_1_ff;
	logic [7:0]  scan_lo_ff;
	logic [5:0]  scan_hi_ff;
	logic [3:0]  irq_status_ff;
	logic [3:0]  irq_mask_ff;
	logic [7:0]  rdata_ff;
	logic [13:0] connect_ff;
	logic [2:0]  gain_ff;
	logic        enable_ff;
	logic        wake_ff;
	logic        irq_ff;

	logic wr_chan;
	logic wr_mode;
	logic wr_mode_1;
	logic wr_scan_lo;
	logic wr_scan_hi;
	logic wr_status;
	logic wr_mask;

	// Each strobe decodes to at most one register, so no write can load two registers.
	assign wr_chan    = wr_i && addr_i == cap_sense_pkg::ADDR_CHANNEL_SELECT;
	assign wr_mode    = wr_i && addr_i == cap_sense_pkg::ADDR_MODE;
	assign wr_mode_1  = wr_i && addr_i == cap_sense_pkg::ADDR_MODE_1;
	assign wr_scan_lo = wr_i && addr_i == cap_sense_pkg::ADDR_SCAN_LO;
	assign wr_scan_hi = wr_i && addr_i == cap_sense_pkg::ADDR_SCAN_HI;
	assign wr_status  = wr_i && addr_i == cap_sense_pkg::ADDR_IRQ_STATUS;
	assign wr_mask    = wr_i && addr_i == cap_sense_pkg::ADDR_IRQ_MASK;

	// Only the low nibble is stored, so the upper bits cannot read back anything but zero.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			channel_select_ff <= cap_sense_pkg::RST_CHANNEL_SELECT;
		end
		else if (wr_chan)
		begin
			channel_select_ff <= wdata_i[3:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mode_ff <= cap_sense_pkg::RST_MODE;
		end
		// Bit 3 is reserved and is always stored as zero.
		else if (wr_mode)
		begin
			mode_ff <= {wdata_i[7:4], 1'b0, wdata_i[2:0]};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mode_1_ff <= cap_sense_pkg::RST_MODE_1;
		end
		// Bit 7 is reserved and is always stored as zero.
		else if (wr_mode_1)
		begin
			mode_1_ff <= {1'b0, wdata_i[6:0]};
		end
	end

	// The two halves of the scan mask load independently; bit n always stands for channel n.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			scan_lo_ff <= cap_sense_pkg::RST_SCAN_LO;
		end
		else if (wr_scan_lo)
		begin
			scan_lo_ff <= wdata_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			scan_hi_ff <= cap_sense_pkg::RST_SCAN_HI;
		end
		else if (wr_scan_hi)
		begin
			scan_hi_ff <= wdata_i[5:0];
		end
	end

	logic [2:0] acc_log;

	// Sets larger than 64 samples are clamped to 64 to fit the counter.
	assign acc_log = (mode_1_ff[cap_sense_pkg::MODE1_ACC_LOG_LSB +: 3] > 3'h6)
		? 3'h6
		: mode_1_ff[cap_sense_pkg::MODE1_ACC_LOG_LSB +: 3];

	assign cfg.channel_code          = channel_select_ff;
	assign cfg.scan_mask             = {scan_hi_ff, scan_lo_ff};
	assign cfg.multi_channel_enable  = mode_1_ff[cap_sense_pkg::MODE1_MCEN_BIT];
	assign cfg.conversion_mode_field = mode_ff[cap_sense_pkg::MODE_CONV_LSB +: 3];
	assign cfg.suspend_wake_enable   = mode_1_ff[cap_sense_pkg::MODE1_SMEN_BIT];
	assign cfg.wake_behaviour_select = mode_1_ff[cap_sense_pkg::MODE1_WBS_BIT];
	assign cfg.acc_enable            = mode_1_ff[cap_sense_pkg::MODE1_ACC_EN_BIT];
	assign cfg.acc_log               = acc_log;
	// Converter events are ignored while software holds the converter off.
	assign cfg.conv_done             = conv_done_i && enable_ff;
	assign cfg.end_of_scan           = end_of_scan_i && enable_ff;
	assign cfg.comp_over             = comp_over_i;
	assign cfg.suspended             = suspended_i;

	channel_mux #(
		.HAS_PORT1_PIN4 (HAS_PORT1_PIN4)
	) u_mux (
		.cfg (cfg.mux)
	);

	wake_ctrl u_wake (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.cfg    (cfg.wake)
	);

	// Registering the connect vector gives the switches one clean change per code write.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			connect_ff <= 14'h0000;
		end
		else
		begin
			connect_ff <= cfg.channel_connect;
		end
	end

	// Code n gives a gain of n+1, so the reset code 111 is 8x.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			gain_ff <= cap_sense_pkg::RST_MODE[cap_sense_pkg::MODE_GAIN_LSB +: 3];
		end
		else
		begin
			gain_ff <= mode_ff[cap_sense_pkg::MODE_GAIN_LSB +: 3];
		end
	end

	// Software owns converter power; the block never switches the converter on by itself.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			enable_ff <= cap_sense_pkg::RST_MODE[cap_sense_pkg::MODE_ENABLE_BIT];
		end
		else
		begin
			enable_ff <= mode_ff[cap_sense_pkg::MODE_ENABLE_BIT];
		end
	end

	// Wake is a one-cycle pulse; a power controller that needs a level must latch it.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wake_ff <= 1'b0;
		end
		else
		begin
			wake_ff <= cfg.wake_evt;
		end
	end

	logic [3:0] irq_events;

	assign irq_events[cap_sense_pkg::IRQ_CONV_DONE] = cfg.sample_evt;
	assign irq_events[cap_sense_pkg::IRQ_END_SCAN]  = cfg.end_of_scan;
	assign irq_events[cap_sense_pkg::IRQ_TOUCH]     = cfg.touch_evt;
	assign irq_events[cap_sense_pkg::IRQ_WAKE]      = cfg.wake_evt;

	// A new event in the same cycle as a write-one-to-clear keeps its bit set.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			irq_status_ff <= cap_sense_pkg::RST_IRQ_STATUS;
		end
		else
		begin
			irq_status_ff <= (irq_status_ff & ~(wr_status ? wdata_i[3:0] : 4'h0)) | irq_events;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			irq_mask_ff <= cap_sense_pkg::RST_IRQ_MASK;
		end
		else if (wr_mask)
		begin
			irq_mask_ff <= wdata_i[3:0];
		end
	end

	// The line follows the status bits by one cycle so that it comes straight from a flop.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= |(irq_status_ff & irq_mask_ff);
		end
	end

	logic [7:0] nxt_rdata;

	// Unmapped addresses and reserved bits read as zero.
	always_comb
	begin
		nxt_rdata = 8'h00;
		case (addr_i)
			cap_sense_pkg::ADDR_CHANNEL_SELECT: nxt_rdata = {4'h0, channel_select_ff};
			cap_sense_pkg::ADDR_MODE:           nxt_rdata = mode_ff;
			cap_sense_pkg::ADDR_MODE_1:         nxt_rdata = mode_1_ff;
			cap_sense_pkg::ADDR_SCAN_LO:        nxt_rdata = scan_lo_ff;
			cap_sense_pkg::ADDR_SCAN_HI:        nxt_rdata = {2'h0, scan_hi_ff};
			cap_sense_pkg::ADDR_IRQ_STATUS:     nxt_rdata = {4'h0, irq_status_ff};
			cap_sense_pkg::ADDR_IRQ_MASK:       nxt_rdata = {4'h0, irq_mask_ff};
			cap_sense_pkg::ADDR_LIVE_STATE:     nxt_rdata = {suspended_i, enable_ff, cfg.acc_count};
			default:                            nxt_rdata = 8'h00;
		endcase
	end

	// Read data stand for the one cycle after the strobe and are zero otherwise.
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			rdata_ff <= 8'h00;
		end
		else if (rd_i)
		begin
			rdata_ff <= nxt_rdata;
		end
		else
		begin
			rdata_ff <= 8'h00;
		end
	end

	assign rdata_o            = rdata_ff;
	assign channel_connect_o  = connect_ff;
	assign gain_select_o      = gain_ff;
	assign converter_enable_o = enable_ff;
	assign wake_o             = wake_ff;
	assign irq_o              = irq_ff;
endmodule : cap_sense_ctrl

/* core/cap_sense_pkg.sv */
package cap_sense_pkg;

	localparam int unsigned NUM_CHANNELS = 14;

	// Register addresses on the plain register port.
	localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'hab;
	localparam logic [7:0] ADDR_MODE           = 8'hac;
	localparam logic [7:0] ADDR_MODE_1         = 8'had;
	localparam logic [7:0] ADDR_SCAN_LO        = 8'hae;
	localparam logic [7:0] ADDR_SCAN_HI        = 8'haf;
	localparam logic [7:0] ADDR_IRQ_STATUS     = 8'hb0;
	localparam logic [7:0] ADDR_IRQ_MASK       = 8'hb1;
	localparam logic [7:0] ADDR_LIVE_STATE     = 8'hb2;

	// Values after reset.
	localparam logic [3:0] RST_CHANNEL_SELECT = 4'h0;
	localparam logic [7:0] RST_MODE           = 8'h70;
	localparam logic [7:0] RST_MODE_1         = 8'h00;
	localparam logic [7:0] RST_SCAN_LO        = 8'h00;
	localparam logic [5:0] RST_SCAN_HI        = 6'h00;
	localparam logic [3:0] RST_IRQ_STATUS     = 4'h0;
	localparam logic [3:0] RST_IRQ_MASK       = 4'h0;

	// Field positions in the mode register.
	localparam int unsigned MODE_ENABLE_BIT = 7;
	localparam int unsigned MODE_GAIN_LSB   = 4;
	localparam int unsigned MODE_CONV_LSB   = 0;

	// Field positions in the second mode register.
	localparam int unsigned MODE1_WBS_BIT     = 0;
	localparam int unsigned MODE1_SMEN_BIT    = 1;
	localparam int unsigned MODE1_MCEN_BIT    = 2;
	localparam int unsigned MODE1_ACC_EN_BIT  = 3;
	localparam int unsigned MODE1_ACC_LOG_LSB = 4;

	// Interrupt status and mask bit positions.
	localparam int unsigned IRQ_CONV_DONE = 0;
	localparam int unsigned IRQ_END_SCAN  = 1;
	localparam int unsigned IRQ_TOUCH     = 2;
	localparam int unsigned IRQ_WAKE      = 3;

	// Channel codes.
	localparam logic [3:0] CODE_PORT1_PIN4 = 4'hc;
	localparam logic [3:0] CODE_LAST_VALID = 4'hd;

	// Conversion mode codes that may wake the device.
	localparam logic [2:0] CONV_WAKE_END_SCAN = 3'h5;
	localparam logic [2:0] CONV_WAKE_EACH_A   = 3'h6;
	localparam logic [2:0] CONV_WAKE_EACH_B   = 3'h7;

endpackage : cap_sense_pkg

/* core/sense_cfg_if.sv */
`timescale 1ns/1ns
interface sense_cfg_if;
	logic [3:0]  channel_code;
	logic [13:0] scan_mask;
	logic        multi_channel_enable;
	logic [2:0]  conversion_mode_field;
	logic        suspend_wake_enable;
	logic        wake_behaviour_select;
	logic        acc_enable;
	logic [2:0]  acc_log;
	logic        conv_done;
	logic        end_of_scan;
	logic        comp_over;
	logic        suspended;
	logic [13:0] channel_connect;
	logic        touch_evt;
	logic        sample_evt;
	logic        wake_evt;
	logic [5:0]  acc_count;

	modport top (
		output channel_code, scan_mask, multi_channel_enable, conversion_mode_field,
		output suspend_wake_enable, wake_behaviour_select, acc_enable, acc_log,
		output conv_done, end_of_scan, comp_over, suspended,
		input  channel_connect, touch_evt, sample_evt, wake_evt, acc_count
	);
	modport mux (
		input  channel_code, scan_mask, multi_channel_enable,
		output channel_connect
	);
	modport wake (
		input  conversion_mode_field, suspend_wake_enable, wake_behaviour_select,
		input  acc_enable, acc_log, conv_done, end_of_scan, comp_over, suspended,
		output touch_evt, sample_evt, wake_evt, acc_count
	);
endinterface : sense_cfg_if

/* core/channel_mux.sv */
`timescale 1ns/1ns
module channel_mux #(
	parameter bit HAS_PORT1_PIN4 = 1'b1
) (
	sense_cfg_if.mux cfg
);
	logic [13:0] single;

	// Codes 1110 and 1111 decode to no channel, so a stray write leaves the input open.
	always_comb
	begin
		single = 14'h0000;
		if (cfg.channel_code <= cap_sense_pkg::CODE_LAST_VALID)
		begin
			single[cfg.channel_code] = 1'b1;
		end
		if (!HAS_PORT1_PIN4 && cfg.channel_code == cap_sense_pkg::CODE_PORT1_PIN4)
		begin
			single = 14'h0000;
		end
	end

	logic [13:0] usable;

	generate
		for (genvar i = 0; i < 14; i++)
		begin : g_pin
			if (i == 12)
			begin : g_p14
				assign usable[i] = HAS_PORT1_PIN4;
			end
			else
			begin : g_other
				assign usable[i] = 1'b1;
			end
		end
	endgenerate

	assign cfg.channel_connect = cfg.multi_channel_enable
		? (cfg.scan_mask & usable)
		: single;
endmodule : channel_mux

/* core/wake_ctrl.sv */
`timescale 1ns/1ns
module wake_ctrl (
	input  wire logic clk_i,
	input  wire logic srst_i,
	sense_cfg_if.wake cfg
);
	logic [5:0] acc_count_ff;
	logic [5:0] acc_last;
	logic       set_done;

	assign acc_last = 6'((7'h01 << cfg.acc_log) - 7'h01);
	// A conversion only completes a set once every accumulated sample is in.
	assign set_done = cfg.conv_done && (!cfg.acc_enable || acc_count_ff == acc_last);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			acc_count_ff <= 6'h00;
		end
		else if (!cfg.acc_enable || set_done)
		begin
			acc_count_ff <= 6'h00;
		end
		else if (cfg.conv_done)
		begin
			acc_count_ff <= acc_count_ff + 6'h01;
		end
	end

	logic eos_wake;
	logic each_wake;

	assign cfg.acc_count  = acc_count_ff;
	assign cfg.sample_evt = set_done;
	// The select bit flips which side of the threshold counts as a touch.
	assign cfg.touch_evt  = set_done && (cfg.comp_over ^ cfg.wake_behaviour_select);
	assign eos_wake  = cfg.suspend_wake_enable && cfg.end_of_scan
		&& cfg.conversion_mode_field == cap_sense_pkg::CONV_WAKE_END_SCAN
		&& (!cfg.acc_enable || acc_count_ff == 6'h00);
	assign each_wake = cfg.suspend_wake_enable && set_done
		&& (cfg.conversion_mode_field == cap_sense_pkg::CONV_WAKE_EACH_A
		|| cfg.conversion_mode_field == cap_sense_pkg::CONV_WAKE_EACH_B);
	// Other mode codes leave only the touch path able to wake.
	assign cfg.wake_evt = cfg.suspended && (cfg.touch_evt || eos_wake || each_wake);
endmodule : wake_ctrl

/* verif/cap_sense_ctrl_asserts.sv */
`timescale 1ns/1ns
module cap_sense_ctrl_asserts #(
	parameter bit HAS_PORT1_PIN4 = 1'b1
) (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic [7:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        conv_done_i,
	input wire logic        end_of_scan_i,
	input wire logic        comp_over_i,
	input wire logic        suspended_i,
	input wire logic [13:0] channel_connect_o,
	input wire logic [2:0]  gain_select_o,
	input wire logic        converter_enable_o,
	input wire logic        wake_o,
	input wire logic        irq_o
);
	logic [7:0]  mode_ff;
	logic [7:0]  mode1_ff;
	logic [13:0] want_conn;
	logic [2:0]  mode_gain;
	logic        mode_on;
	logic        live;
	logic        touch_hit;
	logic        scan_hit;
	logic        conv_hit;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// Shadow copies of the mode registers, so wake rules can be judged from the ports alone.
	always_ff @(posedge clk_i)
		if (srst_i)
			mode_ff <= cap_sense_pkg::RST_MODE;
		else if (wr_i && addr_i == cap_sense_pkg::ADDR_MODE)
			mode_ff <= wdata_i;

	always_ff @(posedge clk_i)
		if (srst_i)
			mode1_ff <= cap_sense_pkg::RST_MODE_1;
		else if (wr_i && addr_i == cap_sense_pkg::ADDR_MODE_1)
			mode1_ff <= wdata_i;

	always_comb
	begin
		want_conn = 14'h0;
		if (wdata_i[3:0] <= cap_sense_pkg::CODE_LAST_VALID
			&& (HAS_PORT1_PIN4 || wdata_i[3:0] != cap_sense_pkg::CODE_PORT1_PIN4))
			want_conn[wdata_i[3:0]] = 1'b1;
	end

	assign mode_gain = mode_ff[6:4];
	assign mode_on = mode_ff[7];
	assign live = converter_enable_o && suspended_i;
	assign touch_hit = conv_done_i && (comp_over_i ^ mode1_ff[0]);
	assign scan_hit = end_of_scan_i && mode1_ff[1] && mode_ff[2:0] == 3'h5;
	assign conv_hit = conv_done_i && mode1_ff[1] && mode_ff[2:1] == 2'b11;

	AST_GAIN_RST: assert property (disable iff (1'b0)
		srst_i |=> gain_select_o == 3'h7) else $error("gain not 8x after reset");
	AST_GAIN_WR: assert property (wr_i && addr_i == cap_sense_pkg::ADDR_MODE
		|=> ##1 gain_select_o == $past(mode_gain)) else $error("gain not applied");
	AST_ENABLE_WR: assert property (wr_i && addr_i == cap_sense_pkg::ADDR_MODE
		|=> ##1 converter_enable_o == $past(mode_on)) else $error("enable not applied");
	AST_CONN_ONE: assert property (wr_i && addr_i == cap_sense_pkg::ADDR_CHANNEL_SELECT
		&& !mode1_ff[2] |=> ##1 channel_connect_o == $past(want_conn, 2))
		else $error("wrong channel connected");
	AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read cycle");
	AST_RD_CHAN: assert property (rd_i && addr_i == 8'hab |=> rdata_o[7:4] == 4'h0)
		else $error("reserved channel bits read high");
	AST_TOUCH_WAKE: assert property (live && !mode1_ff[3] && touch_hit |=> wake_o)
		else $error("touch did not wake");
	AST_SCAN_WAKE: assert property (live && !mode1_ff[3] && scan_hit |=> wake_o)
		else $error("end of scan did not wake");
	AST_CONV_WAKE: assert property (live && !mode1_ff[3] && conv_hit |=> wake_o)
		else $error("conversion did not wake");
	AST_WAKE_CAUSE: assert property (wake_o |-> $past(live)
		&& $past(touch_hit || scan_hit || conv_hit)) else $error("wake without cause");
endmodule : cap_sense_ctrl_asserts

/* verif/touch_pad_model.sv */
`timescale 1ns/1ns
module touch_pad_model (
	input  wire logic clk_i,
	output logic      conv_done_o,
	output logic      end_of_scan_o,
	output logic      comp_over_o
);
	logic touched;
	logic junk_ff = 1'b0;

	initial
	begin
		conv_done_o = 1'b0;
		end_of_scan_o = 1'b0;
		touched = 1'b0;
	end

	// Outside a result cycle the comparator toggles, so a stale level never passes for a touch.
	always @(posedge clk_i)
		junk_ff <= ~junk_ff;
	assign comp_over_o = conv_done_o ? touched : junk_ff;

	task automatic convert(input logic touch, input logic scan_end);
		touched <= touch;
		conv_done_o <= 1'b1;
		end_of_scan_o <= scan_end;
		@(posedge clk_i);
		conv_done_o <= 1'b0;
		end_of_scan_o <= 1'b0;
	endtask : convert
endmodule : touch_pad_model

/* verif/testbench.sv */
`timescale 1ns/1ns
module testbench;
	logic        clk_i;
	logic        srst_i;
	logic [7:0]  addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic        suspended_i;
	logic [7:0]  rdata_o;
	logic [13:0] channel_connect_o;
	logic [2:0]  gain_select_o;
	logic        converter_enable_o;
	logic        wake_o;
	logic        irq_o;
	logic        conv_done;
	logic        end_of_scan;
	logic        comp_over;
	logic        rd_d = 1'b0;
	logic        ev_d = 1'b0;
	logic [7:0]  lo;
	logic [7:0]  hi;
	logic [7:0]  rd_q[$];
	logic        wake_q[$];
	int          error_cnt;
	int          comparisons;

	cap_sense_ctrl u_cap_sense_ctrl (
		.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .conv_done_i(conv_done),
		.end_of_scan_i(end_of_scan), .comp_over_i(comp_over), .suspended_i, .channel_connect_o,
		.gain_select_o, .converter_enable_o, .wake_o, .irq_o
	);
	touch_pad_model u_touch_pad_model (
		.clk_i, .conv_done_o(conv_done), .end_of_scan_o(end_of_scan), .comp_over_o(comp_over)
	);

	always #5 clk_i = ~clk_i;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Returns two edges after the strobe, when registered outputs have settled.
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
	endtask : reg_rd

	task automatic conv(input logic touch, input logic scan_end, input logic exp);
		wake_q.push_back(exp);
		u_touch_pad_model.convert(touch, scan_end);
		repeat (3) @(posedge clk_i);
	endtask : conv

	task automatic end_of_test();
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	always @(posedge clk_i)
	begin
		if (rd_d)
			chk(16'(rdata_o), 16'(rd_q.pop_front()));
		if (ev_d)
			chk(16'(wake_o), 16'(wake_q.pop_front()));
		rd_d <= rd_i;
		ev_d <= conv_done || end_of_scan;
	end

	initial
	begin
		#100000;
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		clk_i = 1'b0;
		srst_i = 1'b1;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		suspended_i = 1'b0;
		void'($urandom(32'h32b7));
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk(16'(gain_select_o), 16'h7);
		for (int a = 'hab; a <= 'hb3; a++)
			reg_rd(8'(a), a == 'hac ? 8'h70 : 8'h00);
		for (int c = 0; c < 16; c++)
		begin
			reg_wr(8'hab, {4'($urandom), 4'(c)});
			chk(16'(channel_connect_o), c < 14 ? 16'(1 << c) : 16'h0);
			reg_rd(8'hab, 8'(c));
		end
		for (int g = 0; g < 8; g++)
		begin
			reg_wr(cap_sense_pkg::ADDR_MODE, {1'b0, 3'(g), 4'h0});
			chk(16'(gain_select_o), 16'(g));
		end
		lo = 8'($urandom);
		hi = 8'($urandom) & 8'h3f;
		reg_wr(cap_sense_pkg::ADDR_SCAN_LO, lo);
		reg_wr(cap_sense_pkg::ADDR_SCAN_HI, hi);
		reg_wr(cap_sense_pkg::ADDR_MODE_1, 8'h04);
		chk(16'(channel_connect_o), 16'({hi[5:0], lo}));
		suspended_i <= 1'b1;
		for (int m = 0; m < 8; m++)
		begin
			reg_wr(cap_sense_pkg::ADDR_MODE, 8'h80 | 8'(m));
			reg_wr(cap_sense_pkg::ADDR_MODE_1, 8'h02);
			conv(1'b0, 1'b1, m >= 5);
			conv(1'b0, 1'b0, m >= 6);
			reg_wr(cap_sense_pkg::ADDR_MODE_1, 8'h00);
			conv(1'b0, 1'b1, 1'b0);
			conv(1'b1, 1'b0, 1'b1);
			reg_wr(cap_sense_pkg::ADDR_MODE_1, 8'h01);
			conv(1'b1, 1'b0, 1'b0);
			conv(1'b0, 1'b0, 1'b1);
		end
		reg_wr(cap_sense_pkg::ADDR_MODE_1, 8'h1a);
		conv(1'b1, 1'b0, 1'b0);
		conv(1'b1, 1'b0, 1'b1);
		reg_wr(cap_sense_pkg::ADDR_MODE_1, 8'h02);
		suspended_i <= 1'b0;
		conv(1'b1, 1'b1, 1'b0);
		reg_wr(cap_sense_pkg::ADDR_IRQ_STATUS, 8'h0f);
		reg_wr(cap_sense_pkg::ADDR_IRQ_MASK, 8'hff);
		reg_rd(cap_sense_pkg::ADDR_IRQ_MASK, 8'h0f);
		conv(1'b0, 1'b0, 1'b0);
		chk(16'(irq_o), 16'h1);
		reg_rd(cap_sense_pkg::ADDR_IRQ_STATUS, 8'h01);
		reg_wr(cap_sense_pkg::ADDR_IRQ_MASK, 8'h00);
		chk(16'(irq_o), 16'h0);
		reg_wr(cap_sense_pkg::ADDR_IRQ_MASK, 8'h01);
		chk(16'(irq_o), 16'h1);
		reg_wr(cap_sense_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk(16'(irq_o), 16'h0);
		reg_wr(cap_sense_pkg::ADDR_MODE, 8'h06);
		suspended_i <= 1'b1;
		conv(1'b1, 1'b1, 1'b0);
		reg_rd(cap_sense_pkg::ADDR_IRQ_STATUS, 8'h00);
		reg_rd(cap_sense_pkg::ADDR_LIVE_STATE, 8'h80);
		repeat (2) @(posedge clk_i);
		end_of_test();
	end
endmodule : testbench

bind cap_sense_ctrl cap_sense_ctrl_asserts #(.HAS_PORT1_PIN4(HAS_PORT1_PIN4)) u_asserts (
	.clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .conv_done_i, .end_of_scan_i,
	.comp_over_i, .suspended_i, .channel_connect_o, .gain_select_o, .converter_enable_o,
	.wake_o, .irq_o
);
